// >>> common/gpcer_pkg.sv
// Constants for the per-pin configuration and event-routing block.
// Assumes a byte-addressed Avalon-MM slave port with 32-bit data.
package gpcer_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int NUM_PORTS = 5;
  localparam int PINS_PER_PORT = 8;
  localparam int NUM_PINS = NUM_PORTS * PINS_PER_PORT;
  localparam logic [4:0] EVENT_PORT_MASK = 5'h13;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_PIN_SELECT = 8'hF0;
  localparam logic [7:0] IDX_PIN_CONFIGURATION = 8'hF1;
  localparam logic [7:0] IDX_PIN_EVENT_ROUTING = 8'hF2;
  localparam logic [7:0] IDX_PIN_LEVEL = 8'hF3;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hF4;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hF5;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SEL_PORT_LSB = 4;
  localparam int SEL_PIN_LSB = 0;
  localparam int CFG_OUT_EN = 0;
  localparam int CFG_PUSH_PULL = 1;
  localparam int CFG_PULLUP = 2;
  localparam int CFG_LOCK = 3;
  localparam int RT_HOST_IRQ = 0;
  localparam int RT_SMI = 1;
  localparam int RT_WAKEUP = 2;
  localparam int LVL_OUT_VALUE = 0;
  localparam int LVL_IN_VALUE = 1;
  localparam int ST_HOST_IRQ = 0;
  localparam int ST_SMI = 1;
  localparam int ST_WAKEUP = 2;
  localparam int ST_LOCK_VIOL = 3;

  // ****************************************************************
  // Field masks and reset values
  // ****************************************************************
  localparam logic [7:0] SEL_WRITE_MASK = 8'h77;
  localparam logic [7:0] CFG_FROZEN_MASK = 8'h07;
  localparam logic [7:0] CFG_EVENT_MASK = 8'h70;
  localparam logic [7:0] CFG_PLAIN_MASK = 8'h0F;
  localparam logic [7:0] CFG_RESET_EVENT = 8'h44;
  localparam logic [7:0] CFG_RESET_PLAIN = 8'h04;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [2:0] ROUTE_RESET = 3'h0;
  localparam logic [3:0] IRQ_RESET = 4'h0;

endpackage

// >>> hw/gpcer_top.sv
// Per-pin GPIO configuration, lock and event routing behind an Avalon-MM slave.
// Assumes event pulses come from detection logic on sys_clk_i, and pin
// levels arrive asynchronously from the pads.
//
// Chosen here: the Avalon-MM interface to the registers.

module gpcer_top #(
  parameter int NUM_PINS = gpcer_pkg::NUM_PINS
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [NUM_PINS-1:0] pin_in_i,
  input wire logic [NUM_PINS-1:0] pin_event_i,
  output logic [NUM_PINS-1:0] pin_out_o,
  output logic [NUM_PINS-1:0] pin_oe_n_o,
  output logic [NUM_PINS-1:0] pullup_en_o,
  output logic host_irq_o,
  output logic system_management_interrupt_o,
  output logic power_wakeup_request_o,
  output logic irq_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] sel;
    logic [NUM_PINS-1:0][7:0] cfg;
    logic [NUM_PINS-1:0][2:0] route;
    logic [NUM_PINS-1:0] out_val;
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [3:0] status;
    logic [3:0] mask;
    logic ack;
    logic [31:0] rdata;
    logic host_irq;
    logic system_management_interrupt;
    logic wakeup;
  } gpcer_state_t;

  gpcer_state_t state_q;
  gpcer_state_t state_d;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic gpcer_is_event_pin(input int unsigned pin);
    gpcer_is_event_pin = gpcer_pkg::EVENT_PORT_MASK[pin / gpcer_pkg::PINS_PER_PORT];
  endfunction

  function automatic logic [7:0] gpcer_cfg_reset(input int unsigned pin);
    gpcer_cfg_reset = gpcer_is_event_pin(pin) ? gpcer_pkg::CFG_RESET_EVENT : gpcer_pkg::CFG_RESET_PLAIN;
  endfunction

  function automatic gpcer_state_t gpcer_reset_state();
    gpcer_state_t s;
    s = '0;
    s.sel = gpcer_pkg::SEL_RESET;
    for (int i = 0; i < NUM_PINS; i++) begin
      s.cfg[i] = gpcer_cfg_reset(i);
      s.route[i] = gpcer_pkg::ROUTE_RESET;
    end
    s.status = gpcer_pkg::IRQ_RESET;
    s.mask = gpcer_pkg::IRQ_RESET;
    gpcer_reset_state = s;
  endfunction

  // ****************************************************************
  // Decode of the selector and bus request
  // ****************************************************************
  logic [2:0] sel_port;
  logic [2:0] sel_pin;
  logic [5:0] sel_idx;
  logic sel_valid;
  logic sel_event;
  logic [7:0] reg_idx;
  logic bus_req;
  logic bus_take;
  logic wr_take;
  logic [NUM_PINS-1:0] routed_host;
  logic [NUM_PINS-1:0] routed_smi;
  logic [NUM_PINS-1:0] routed_wake;

  assign sel_port = state_q.sel[gpcer_pkg::SEL_PORT_LSB +: 3];
  assign sel_pin = state_q.sel[gpcer_pkg::SEL_PIN_LSB +: 3];
  assign sel_idx = {sel_port, sel_pin};
  // Reserved port codes select nothing: reads give zero, writes drop
  assign sel_valid = (int'(sel_idx) < NUM_PINS);
  assign sel_event = sel_valid && gpcer_is_event_pin(int'(sel_idx));
  assign reg_idx = avs_address_i[9:2];
  assign bus_req = avs_read_i | avs_write_i;
  assign bus_take = bus_req & state_q.ack;
  assign wr_take = bus_take & avs_write_i & avs_byteenable_i[0];

  // Fixed one-cycle wait: read data is registered and ready when waitrequest drops
  assign avs_waitrequest_o = bus_req & ~state_q.ack;
  assign avs_readdata_o = state_q.rdata;

  // ****************************************************************
  // Per-pin routing and pad controls
  // ****************************************************************
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    assign routed_host[g] = pin_event_i[g] & state_q.route[g][gpcer_pkg::RT_HOST_IRQ];
    assign routed_smi[g] = pin_event_i[g] & state_q.route[g][gpcer_pkg::RT_SMI];
    assign routed_wake[g] = pin_event_i[g] & state_q.route[g][gpcer_pkg::RT_WAKEUP];
    // Open-drain only sinks: the driver turns on for a low value
    assign pin_oe_n_o[g] = ~(state_q.cfg[g][gpcer_pkg::CFG_OUT_EN]
      & (state_q.cfg[g][gpcer_pkg::CFG_PUSH_PULL] | ~state_q.out_val[g]));
    assign pullup_en_o[g] = state_q.cfg[g][gpcer_pkg::CFG_PULLUP];
  end

  assign pin_out_o = state_q.out_val;
  assign host_irq_o = state_q.host_irq;
  assign system_management_interrupt_o = state_q.system_management_interrupt;
  assign power_wakeup_request_o = state_q.wakeup;
  assign irq_o = |(state_q.status & state_q.mask);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [7:0] wdata;
    logic [7:0] cur_cfg;
    logic [7:0] new_cfg;
    logic [7:0] rd;
    logic lock_viol;
    wdata = avs_writedata_i[7:0];
    cur_cfg = sel_valid ? state_q.cfg[sel_idx] : 8'h00;
    new_cfg = cur_cfg;
    rd = 8'h00;
    lock_viol = 1'b0;
    state_d = state_q;

    // Pad inputs are always sampled, whatever the output enable says
    state_d.sync1 = pin_in_i;
    state_d.sync2 = state_q.sync1;

    state_d.host_irq = |routed_host;
    state_d.system_management_interrupt = |routed_smi;
    state_d.wakeup = |routed_wake;

    state_d.ack = bus_req & ~state_q.ack;

    // Read data is captured one cycle ahead of the accepting edge
    unique case (reg_idx)
      gpcer_pkg::IDX_PIN_SELECT: rd = state_q.sel;
      gpcer_pkg::IDX_PIN_CONFIGURATION: rd = cur_cfg;
      gpcer_pkg::IDX_PIN_EVENT_ROUTING: rd = sel_event ? {5'h00, state_q.route[sel_idx]} : 8'h00;
      gpcer_pkg::IDX_PIN_LEVEL: rd = sel_valid ? {6'h00, state_q.sync2[sel_idx], state_q.out_val[sel_idx]} : 8'h00;
      gpcer_pkg::IDX_IRQ_STATUS: rd = {4'h0, state_q.status};
      gpcer_pkg::IDX_IRQ_MASK: rd = {4'h0, state_q.mask};
      default: rd = 8'h00;
    endcase
    if (avs_read_i && !state_q.ack) begin
      state_d.rdata = {24'h000000, rd};
    end

    if (wr_take) begin
      unique case (reg_idx)
        gpcer_pkg::IDX_PIN_SELECT: state_d.sel = wdata & gpcer_pkg::SEL_WRITE_MASK;
        gpcer_pkg::IDX_PIN_CONFIGURATION: begin
          if (sel_valid) begin
            new_cfg = wdata & (sel_event ? (gpcer_pkg::CFG_EVENT_MASK | gpcer_pkg::CFG_PLAIN_MASK)
              : gpcer_pkg::CFG_PLAIN_MASK);
            new_cfg[gpcer_pkg::CFG_LOCK] = new_cfg[gpcer_pkg::CFG_LOCK] | cur_cfg[gpcer_pkg::CFG_LOCK];
            if (cur_cfg[gpcer_pkg::CFG_LOCK]) begin
              lock_viol = |((new_cfg ^ cur_cfg) & gpcer_pkg::CFG_FROZEN_MASK);
              new_cfg = (new_cfg & ~gpcer_pkg::CFG_FROZEN_MASK) | (cur_cfg & gpcer_pkg::CFG_FROZEN_MASK);
            end
            state_d.cfg[sel_idx] = new_cfg;
          end
        end
        gpcer_pkg::IDX_PIN_EVENT_ROUTING: begin
          if (sel_event) begin
            state_d.route[sel_idx] = wdata[2:0];
          end
        end
        gpcer_pkg::IDX_PIN_LEVEL: begin
          if (sel_valid) begin
            if (cur_cfg[gpcer_pkg::CFG_LOCK]) begin
              lock_viol = wdata[gpcer_pkg::LVL_OUT_VALUE] != state_q.out_val[sel_idx];
            end else begin
              state_d.out_val[sel_idx] = wdata[gpcer_pkg::LVL_OUT_VALUE];
            end
          end
        end
        gpcer_pkg::IDX_IRQ_STATUS: state_d.status = state_q.status & ~wdata[3:0];
        gpcer_pkg::IDX_IRQ_MASK: state_d.mask = wdata[3:0];
        default: state_d.status = state_d.status;
      endcase
    end

    // Set after clear so an event in the clearing cycle is kept
    state_d.status[gpcer_pkg::ST_HOST_IRQ] = state_d.status[gpcer_pkg::ST_HOST_IRQ] | (|routed_host);
    state_d.status[gpcer_pkg::ST_SMI] = state_d.status[gpcer_pkg::ST_SMI] | (|routed_smi);
    state_d.status[gpcer_pkg::ST_WAKEUP] = state_d.status[gpcer_pkg::ST_WAKEUP] | (|routed_wake);
    state_d.status[gpcer_pkg::ST_LOCK_VIOL] = state_d.status[gpcer_pkg::ST_LOCK_VIOL] | lock_viol;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= gpcer_reset_state();
    end else begin
      state_q <= state_d;
    end
  end

endmodule

// >>> tb/gpcer_asserts.sv
// Port-level checker for the pin configuration and event routing block.
// Assumes one clock domain; bound to the top module at the foot of this file.
module gpcer_asserts #(
  parameter int NUM_PINS = 40
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [NUM_PINS-1:0] pin_event_i,
  input wire logic [NUM_PINS-1:0] pin_out_o,
  input wire logic [NUM_PINS-1:0] pin_oe_n_o,
  input wire logic [NUM_PINS-1:0] pullup_en_o,
  input wire logic host_irq_o,
  input wire logic system_management_interrupt_o,
  input wire logic power_wakeup_request_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_req; $rose(avs_read_i | avs_write_i); endsequence
  sequence s_one_wait; avs_waitrequest_o ##1 !avs_waitrequest_o; endsequence
  sequence s_released; $rose(reset_n_i); endsequence
  AST_ONE_WAIT: assert property (s_req |-> s_one_wait)
    else $error("request not answered after one wait cycle");
  AST_RD_UPPER: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_RST_PIN: assert property (s_released |-> &pullup_en_o && &pin_oe_n_o && pin_out_o == '0)
    else $error("pin outputs wrong after reset");
  AST_RST_ROUTE: assert property (s_released |-> !(host_irq_o || system_management_interrupt_o
    || power_wakeup_request_o || irq_o))
    else $error("routing outputs high after reset");
  // Pin controls may move only through an accepted write
  AST_FROZEN: assert property (!avs_write_i |=> $stable(pin_out_o) && $stable(pin_oe_n_o)
    && $stable(pullup_en_o))
    else $error("pin control changed without a write");
  AST_HOST_CAUSE: assert property ($rose(host_irq_o) |-> $past(|pin_event_i))
    else $error("host interrupt without an event");
  AST_QUIET: assert property ((pin_event_i == '0) [*2] |-> !(host_irq_o || system_management_interrupt_o
    || power_wakeup_request_o))
    else $error("routing output high with no event");
  AST_IRQ_CAUSE: assert property ($rose(irq_o) |-> $past(|pin_event_i) || $past(avs_write_i))
    else $error("interrupt rose without event or write");
endmodule

bind gpcer_top gpcer_asserts #(.NUM_PINS(NUM_PINS)) gpcer_asserts_i (
  .sys_clk_i(sys_clk_i),
  .reset_n_i(reset_n_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .pin_event_i(pin_event_i),
  .pin_out_o(pin_out_o),
  .pin_oe_n_o(pin_oe_n_o),
  .pullup_en_o(pullup_en_o),
  .host_irq_o(host_irq_o),
  .system_management_interrupt_o(system_management_interrupt_o),
  .power_wakeup_request_o(power_wakeup_request_o),
  .irq_o(irq_o)
);

// >>> tb/tb_top.sv
// Self-checking bench for the pin configuration and event routing block.
// Assumes the checker is bound from its own file; one 125 MHz clock.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] SEL = gpcer_pkg::IDX_PIN_SELECT;
  localparam logic [7:0] CFG = gpcer_pkg::IDX_PIN_CONFIGURATION;
  localparam logic [7:0] RT = gpcer_pkg::IDX_PIN_EVENT_ROUTING;
  localparam logic [7:0] LVL = gpcer_pkg::IDX_PIN_LEVEL;
  localparam logic [7:0] STA = gpcer_pkg::IDX_IRQ_STATUS;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [9:0] avs_address_i = 10'h000;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [39:0] pin_in_i = 40'h0;
  logic [39:0] pin_event_i = 40'h0;
  logic [31:0] avs_readdata_o, lfsr_q;
  logic [39:0] pin_out_o, pin_oe_n_o, pullup_en_o;
  logic avs_waitrequest_o, host_irq_o, system_management_interrupt_o, power_wakeup_request_o, irq_o;
  logic [7:0] v, c;
  logic [2:0] rt_seen;
  int err_count = 0;
  int n_checks = 0;
  int k, p, i;
  gpcer_top gpcer_top_i (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .pin_in_i(pin_in_i),
    .pin_event_i(pin_event_i),
    .pin_out_o(pin_out_o),
    .pin_oe_n_o(pin_oe_n_o),
    .pullup_en_o(pullup_en_o),
    .host_irq_o(host_irq_o),
    .system_management_interrupt_o(system_management_interrupt_o),
    .power_wakeup_request_o(power_wakeup_request_o),
    .irq_o(irq_o)
  );
  assign rt_seen = {power_wakeup_request_o, system_management_interrupt_o, host_irq_o};
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Routed outputs exist only on ports with event detection
  function automatic logic [2:0] exp_route(input int port, input int b);
    return gpcer_pkg::EVENT_PORT_MASK[port] ? 3'h1 << b : 3'h0;
  endfunction
  // Open-drain drives only a low value
  function automatic logic exp_oe_n(input logic [7:0] cf, input logic o);
    return !(cf[0] && (cf[1] || !o));
  endfunction
  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] dat);
    @(posedge sys_clk_i);
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_address_i <= {idx, 2'h0};
    avs_writedata_i <= {lfsr_q[31:8], dat};
    @(posedge sys_clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge sys_clk_i);
    v = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic print_verdict();
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (30000) @(posedge sys_clk_i);
    err_count++;
    $display("[FAIL] watchdog expected finish seen timeout");
    print_verdict();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    lfsr_q = 32'h9A93AA58;
    repeat (3) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    chk("pullup_en_o", '1, pullup_en_o);
    for (k = 0; k < 5; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      c = {1'b0, k[2:0], 1'b0, lfsr_q[2:0]};
      bus(1'b1, SEL, c);
      bus(1'b0, CFG, 8'h00);
      chk("cfg reset", gpcer_pkg::EVENT_PORT_MASK[k] ? 8'h44 : 8'h04, v);
      bus(1'b0, RT, 8'h00);
      chk("route reset", 8'h00, v);
      bus(1'b1, RT, 8'hFF);
      bus(1'b0, RT, 8'h00);
      chk("route", gpcer_pkg::EVENT_PORT_MASK[k] ? 8'h07 : 8'h00, v);
      for (int b = 0; b < 3; b++) begin
        bus(1'b1, RT, 8'h01 << b);
        @(posedge sys_clk_i);
        pin_event_i[k * 8 + c[2:0]] <= 1'b1;
        @(posedge sys_clk_i);
        pin_event_i <= '0;
        @(posedge sys_clk_i);
        chk("route out", exp_route(k, b), rt_seen);
      end
    end
    // Status latched all three routed events while masked off
    chk("irq masked", 1'b0, irq_o);
    bus(1'b1, gpcer_pkg::IDX_IRQ_MASK, 8'h04);
    bus(1'b1, STA, 8'h03);
    bus(1'b0, STA, 8'h00);
    chk("status", 8'h04, v);
    chk("irq", 1'b1, irq_o);
    bus(1'b1, STA, 8'h04);
    bus(1'b0, STA, 8'h00);
    chk("irq clear", 1'b0, irq_o);
    pin_in_i <= {lfsr_q, lfsr_q[7:0]};
    for (k = 0; k < 12; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      p = lfsr_q[15:8] % 5;
      i = p * 8 + lfsr_q[2:0];
      bus(1'b1, SEL, {1'b0, p[2:0], 1'b0, lfsr_q[2:0]});
      bus(1'b1, CFG, lfsr_q[23:16] & 8'h07);
      bus(1'b1, LVL, {7'h0, lfsr_q[24]});
      bus(1'b0, CFG, 8'h00);
      chk("cfg", lfsr_q[23:16] & 8'h07, v);
      bus(1'b0, LVL, 8'h00);
      chk("in level", pin_in_i[i], v[1]);
      chk("pullup", lfsr_q[18], pullup_en_o[i]);
      chk("oe_n", exp_oe_n(lfsr_q[23:16], lfsr_q[24]), pin_oe_n_o[i]);
      chk("out value", lfsr_q[24], pin_out_o[i]);
    end
    bus(1'b1, SEL, 8'h13);
    bus(1'b1, LVL, 8'h00);
    bus(1'b1, CFG, 8'h0B);
    bus(1'b1, CFG, 8'h04);
    bus(1'b1, LVL, 8'h01);
    bus(1'b0, CFG, 8'h00);
    chk("locked cfg", 8'h0B, v);
    chk("locked out", 2'h0, {pullup_en_o[11], pin_out_o[11]});
    bus(1'b0, STA, 8'h00);
    chk("lock flag", 8'h08, v);
    // Low byte lane off must leave the selector alone
    avs_byteenable_i <= 4'h0;
    bus(1'b1, SEL, 8'h14);
    avs_byteenable_i <= 4'hF;
    bus(1'b0, SEL, 8'h00);
    chk("sel", 8'h13, v);
    bus(1'b1, 8'h10, 8'hFF);
    bus(1'b0, 8'h10, 8'h00);
    chk("unmapped", 8'h00, v);
    // Port code 5 is reserved: nothing behind it
    bus(1'b1, SEL, 8'h50);
    bus(1'b1, CFG, 8'h07);
    bus(1'b0, CFG, 8'h00);
    chk("reserved port", 8'h00, v);
    bus(1'b0, gpcer_pkg::IDX_IRQ_MASK, 8'h00);
    chk("mask", 8'h04, v);
    @(posedge sys_clk_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    bus(1'b1, SEL, 8'h13);
    bus(1'b0, CFG, 8'h00);
    chk("cfg after reset", 8'h44, v);
    print_verdict();
  end
endmodule
